/* File: include/ctsb_pkg.sv */
// constants, register map and state codes of the transformer supervision block
// Functional notes
// - Blocking input is sampled each processing cycle before the pick-up result is used.
// - Pick-up without blocking raises start and loads the alarm delay timer.
// - Pick-up with blocking raises blocked instead of start; no timing runs.
// - Blocking during start clears start and releases timing as a pick-up drop.
// - Entering blocked emits a time-stamped event with fault code and process data.
// - With stage forcing enabled, a software switch drives the blocking input.
// - Alarm timing is definite fixed delay only, no inverse curves.
// - All conditions start the delay; alarm only if they persist to expiry.
// - Any phase above the upper limit keeps the block inactive.
// - All phases below the lower limit keep the block inactive.
// - With residual selected, phase-sum and measured residual are compared.
// - With residual selected, activation needs the residual difference at its limit.
// - Without residual comparison, primary and secondary phase loss alarm alike.
// - Alarm/block on/off events; user selects on, off or both for the buffer. The selection gates only the event port; history stores every on event.
// - Each event carries a time stamp and captured process data.
// - Twelve-entry history per instance, oldest record overwritten.
// - History holds time, event, currents, time to alarm, fault code, setting group.
// - Needs min/max phase ratio below setting and neg/pos ratio above setting.
// - Alarm delay is set in 5 ms steps from activation to alarm.
// - Compensation command captures the calculated residual as offset.
package ctsb_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_HIGH = 8'h04;
  localparam logic [7:0] A_LOW = 8'h08;
  localparam logic [7:0] A_RATIO = 8'h0c;
  localparam logic [7:0] A_NPRATIO = 8'h10;
  localparam logic [7:0] A_DIFF = 8'h14;
  localparam logic [7:0] A_DELAY = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [7:0] A_HSEL = 8'h20;
  localparam logic [7:0] A_HTIME = 8'h24;
  localparam logic [7:0] A_HINFO = 8'h28;
  localparam logic [7:0] A_HPH01 = 8'h2c;
  localparam logic [7:0] A_HPH2R = 8'h30;
  localparam logic [7:0] A_HSEQ = 8'h34;
  localparam int C_RES_EN = 0;
  localparam int C_FORCE_EN = 1;
  localparam int C_FORCE_BLK = 2;
  localparam int C_EV_ON = 3;
  localparam int C_EV_OFF = 4;
  localparam int C_COMP = 5;
  localparam logic [4:0] CTRL_RST = 5'h18;
  localparam logic [15:0] HIGH_RST = 16'h0078;
  localparam logic [15:0] LOW_RST = 16'h000a;
  localparam logic [15:0] RATIO_RST = 16'h03e8;
  localparam logic [15:0] NPRATIO_RST = 16'h1324;
  localparam logic [15:0] DIFF_RST = 16'h000a;
  localparam logic [15:0] DELAY_RST = 16'h0064;
  localparam logic [31:0] RATIO_FULL = 32'h0000_2710;
  localparam int EV_ALM_ON = 0;
  localparam int EV_ALM_OFF = 1;
  localparam int EV_BLK_ON = 2;
  localparam int EV_BLK_OFF = 3;
  localparam int HIST_DEPTH = 12;
  localparam logic [3:0] HIST_LAST = 4'hb;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_STEP_NS = 5000000;
  localparam int STEP_CYCLES_DEF = DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_ALARM = 4'b0100,
    ST_BLOCK = 4'b1000
  } ctsb_state_e;
endpackage

/* File: src/ctsb_top.sv */
// transformer supervision: pick-up checks, fixed-delay alarm, blocking, events, history
`timescale 1ns/1ps
module ctsb_top import ctsb_pkg::*; #(
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cycle_tick,
  input wire logic [15:0] phase_a,
  input wire logic [15:0] phase_b,
  input wire logic [15:0] phase_c,
  input wire logic [15:0] residual_current,
  input wire logic [15:0] phase_sum,
  input wire logic [15:0] pos_seq,
  input wire logic [15:0] neg_seq,
  input wire logic block_in,
  input wire logic [31:0] time_stamp,
  input wire logic [2:0] setting_group,
  output logic start_o,
  output logic blocked_o,
  output logic alarm_o,
  output logic evt_valid,
  output logic [3:0] evt_flags,
  output logic [31:0] evt_time,
  output logic [4:0] evt_fault,
  output logic [15:0] evt_remain
);
  logic [4:0] ctrl_reg, fault;
  logic [15:0] high_reg, low_reg, ratio_reg, npratio_reg, diff_reg, delay_reg;
  logic [15:0] offset_reg, remain_reg, imax, imin;
  logic [17:0] res_diff, res_abs;
  logic [3:0] hsel_reg, wstrb_reg, ev, ev_mask, hptr_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rd_mux, step_cnt;
  logic have_aw, have_w, wr_go, rd_hit, step_tick, hist_we;
  ctsb_state_e st_reg, st_next;
  logic blk_now, blk_reg, pickup, load_timer;
  logic f_high, f_low, f_ratio, f_np, f_res;
  logic [31:0] h_time [HIST_DEPTH];
  logic h_code [HIST_DEPTH];
  logic [15:0] h_a [HIST_DEPTH], h_b [HIST_DEPTH], h_c [HIST_DEPTH], h_r [HIST_DEPTH];
  logic [15:0] h_p [HIST_DEPTH], h_n [HIST_DEPTH], h_rem [HIST_DEPTH];
  logic [4:0] h_flt [HIST_DEPTH];
  logic [2:0] h_sg [HIST_DEPTH];

  function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] d, logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // axi4-lite write side: address and data taken in either order
  assign wr_go = have_aw && have_w && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      have_aw <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      have_aw <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      have_aw <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      have_w <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      have_w <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      have_w <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg <= A_HSEL && awaddr_reg != A_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // settings; compensation bit is a command, never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      high_reg <= HIGH_RST;
      low_reg <= LOW_RST;
      ratio_reg <= RATIO_RST;
      npratio_reg <= NPRATIO_RST;
      diff_reg <= DIFF_RST;
      delay_reg <= DELAY_RST;
      hsel_reg <= 4'h0;
    end else if (wr_go) begin
      unique case (awaddr_reg)
        A_CTRL: if (wstrb_reg[0]) ctrl_reg <= wdata_reg[4:0];
        A_HIGH: high_reg <= merge16(high_reg, wdata_reg, wstrb_reg);
        A_LOW: low_reg <= merge16(low_reg, wdata_reg, wstrb_reg);
        A_RATIO: ratio_reg <= merge16(ratio_reg, wdata_reg, wstrb_reg);
        A_NPRATIO: npratio_reg <= merge16(npratio_reg, wdata_reg, wstrb_reg);
        A_DIFF: diff_reg <= merge16(diff_reg, wdata_reg, wstrb_reg);
        A_DELAY: delay_reg <= merge16(delay_reg, wdata_reg, wstrb_reg);
        A_HSEL: if (wstrb_reg[0])
          hsel_reg <= (wdata_reg[3:0] > HIST_LAST) ? HIST_LAST : wdata_reg[3:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      offset_reg <= 16'h0000;
    end else if (wr_go && awaddr_reg == A_CTRL && wstrb_reg[0] && wdata_reg[C_COMP]) begin
      offset_reg <= phase_sum;
    end
  end

  // read side, one cycle after the address is taken
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      A_CTRL: rd_mux = {27'h0, ctrl_reg};
      A_HIGH: rd_mux = {16'h0, high_reg};
      A_LOW: rd_mux = {16'h0, low_reg};
      A_RATIO: rd_mux = {16'h0, ratio_reg};
      A_NPRATIO: rd_mux = {16'h0, npratio_reg};
      A_DIFF: rd_mux = {16'h0, diff_reg};
      A_DELAY: rd_mux = {16'h0, delay_reg};
      A_STATUS: rd_mux = {remain_reg, hptr_reg, blk_reg, st_reg, 2'h0, fault};
      A_HSEL: rd_mux = {28'h0, hsel_reg};
      A_HTIME: rd_mux = h_time[hsel_reg];
      A_HINFO: rd_mux = {h_rem[hsel_reg], 5'h00, h_sg[hsel_reg], h_flt[hsel_reg],
                         2'h0, h_code[hsel_reg]};
      A_HPH01: rd_mux = {h_b[hsel_reg], h_a[hsel_reg]};
      A_HPH2R: rd_mux = {h_r[hsel_reg], h_c[hsel_reg]};
      A_HSEQ: rd_mux = {h_n[hsel_reg], h_p[hsel_reg]};
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pick-up conditions, evaluated combinationally from the present measurements
  always_comb begin
    imax = (phase_a > phase_b) ? phase_a : phase_b;
    imax = (phase_c > imax) ? phase_c : imax;
    imin = (phase_a < phase_b) ? phase_a : phase_b;
    imin = (phase_c < imin) ? phase_c : imin;
    f_high = (phase_a > high_reg) || (phase_b > high_reg) || (phase_c > high_reg);
    f_low = (phase_a < low_reg) && (phase_b < low_reg) && (phase_c < low_reg);
    f_ratio = ({16'h0, imin} * RATIO_FULL) < ({16'h0, ratio_reg} * {16'h0, imax});
    f_np = ({16'h0, neg_seq} * RATIO_FULL) > ({16'h0, npratio_reg} * {16'h0, pos_seq});
    res_diff = {2'b00, phase_sum} - {2'b00, offset_reg} - {2'b00, residual_current};
    res_abs = res_diff[17] ? (18'h0 - res_diff) : res_diff;
    // a zero difference means a primary-side event, so it must not alarm
    f_res = !ctrl_reg[C_RES_EN] || (res_abs >= {2'b00, diff_reg});
    pickup = !f_high && !f_low && f_ratio && f_np && f_res;
    fault = {f_res, f_np, f_ratio, f_low, f_high};
    blk_now = ctrl_reg[C_FORCE_EN] ? ctrl_reg[C_FORCE_BLK] : block_in;
  end

  // 5 ms step enable for the definite delay
  always_ff @(posedge clk) begin
    if (rst || step_cnt == 32'(STEP_CYCLES - 1)) begin
      step_cnt <= 32'h0000_0000;
    end else begin
      step_cnt <= step_cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      step_tick <= 1'b0;
    end else begin
      step_tick <= (step_cnt == 32'(STEP_CYCLES - 1));
    end
  end

  // supervision state machine; a processing cycle outranks a timer expiry
  always_comb begin
    st_next = st_reg;
    ev = 4'h0;
    load_timer = 1'b0;
    if (cycle_tick) begin
      unique case (st_reg)
        ST_IDLE: begin
          if (pickup && blk_now) begin
            st_next = ST_BLOCK;
            ev[EV_BLK_ON] = 1'b1;
          end else if (pickup) begin
            st_next = ST_START;
            load_timer = 1'b1;
          end
        end
        ST_START: begin
          if (pickup && blk_now) begin
            st_next = ST_BLOCK;
            ev[EV_BLK_ON] = 1'b1;
          end else if (!pickup) begin
            st_next = ST_IDLE;
          end
        end
        ST_ALARM: begin
          if (!pickup) begin
            st_next = ST_IDLE;
            ev[EV_ALM_OFF] = 1'b1;
          end else if (blk_now) begin
            st_next = ST_BLOCK;
            ev[EV_ALM_OFF] = 1'b1;
            ev[EV_BLK_ON] = 1'b1;
          end
        end
        ST_BLOCK: begin
          if (!pickup || !blk_now) begin
            st_next = pickup ? ST_START : ST_IDLE;
            load_timer = pickup;
            ev[EV_BLK_OFF] = 1'b1;
          end
        end
      endcase
    end else if (st_reg == ST_START && step_tick && remain_reg == 16'h0000) begin
      st_next = ST_ALARM;
      ev[EV_ALM_ON] = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      blk_reg <= 1'b0;
      start_o <= 1'b0;
      blocked_o <= 1'b0;
      alarm_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (cycle_tick) blk_reg <= blk_now;
      start_o <= (st_next == ST_START) || (st_next == ST_ALARM);
      blocked_o <= (st_next == ST_BLOCK);
      alarm_o <= (st_next == ST_ALARM);
    end
  end
  always_ff @(posedge clk) begin
    if (rst || load_timer) begin
      remain_reg <= rst ? 16'h0000 : delay_reg;
    end else if (st_reg != ST_START) begin
      remain_reg <= 16'h0000;
    end else if (step_tick && remain_reg != 16'h0000) begin
      remain_reg <= remain_reg - 16'h0001;
    end
  end

  // event port: filtered by on/off selection, history records every on event
  assign ev_mask = {2{ctrl_reg[C_EV_OFF], ctrl_reg[C_EV_ON]}};
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_valid <= 1'b0;
      evt_flags <= 4'h0;
      evt_time <= 32'h0000_0000;
      evt_fault <= 5'h00;
      evt_remain <= 16'h0000;
    end else begin
      evt_flags <= ev & ev_mask;
      evt_valid <= |(ev & ev_mask);
      if (|ev) begin
        evt_time <= time_stamp;
        evt_fault <= fault;
        evt_remain <= remain_reg;
      end
    end
  end
  assign hist_we = ev[EV_ALM_ON] || ev[EV_BLK_ON];
  always_ff @(posedge clk) begin
    if (rst) begin
      hptr_reg <= 4'h0;
    end else if (hist_we) begin
      hptr_reg <= (hptr_reg == HIST_LAST) ? 4'h0 : hptr_reg + 4'h1;
    end
  end
  // plain flops with no reset keep the history area small
  for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
    always_ff @(posedge clk) begin
      if (hist_we && hptr_reg == 4'(i)) begin
        h_time[i] <= time_stamp;
        h_code[i] <= ev[EV_BLK_ON];
        h_a[i] <= phase_a;
        h_b[i] <= phase_b;
        h_c[i] <= phase_c;
        h_r[i] <= residual_current;
        h_p[i] <= pos_seq;
        h_n[i] <= neg_seq;
        h_rem[i] <= remain_reg;
        h_flt[i] <= fault;
        h_sg[i] <= setting_group;
      end
    end
  end
endmodule // ctsb_top

/* File: testbench/ctsb_top_chk.sv */
// port-level assertion checker for the supervision block
`timescale 1ns/1ps
module ctsb_top_chk import ctsb_pkg::*; #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cycle_tick,
  input wire logic block_in,
  input wire logic [31:0] time_stamp,
  input wire logic start_o,
  input wire logic blocked_o,
  input wire logic alarm_o,
  input wire logic evt_valid,
  input wire logic [3:0] evt_flags,
  input wire logic [31:0] evt_time
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] start_cnt;
  // cycles spent in start, bounds the fixed delay from below
  always_ff @(posedge clk) begin
    if (rst || !start_o) begin
      start_cnt <= 32'h0;
    end else begin
      start_cnt <= start_cnt + 32'h1;
    end
  end
  sequence s_blk_entry;
    blocked_o && evt_valid && evt_flags[2] && evt_time == $past(time_stamp);
  endsequence
  AST_START_NOT_BLOCKED: assert property (!(start_o && blocked_o))
    else $error("start and blocked both high");
  AST_ALARM_WITH_START: assert property (alarm_o |-> start_o)
    else $error("alarm without start");
  AST_START_ON_TICK: assert property (
    $rose(start_o) |-> $past(cycle_tick) && !$past(block_in))
    else $error("start rose off tick or while blocked");
  AST_BLOCK_ENTRY: assert property (
    $rose(blocked_o) |-> $past(cycle_tick) ##0 s_blk_entry)
    else $error("block entry without stamped event");
  AST_ALARM_ON_EVT: assert property ($rose(alarm_o) |-> evt_valid && evt_flags[0])
    else $error("alarm rose without event");
  AST_ALARM_OFF: assert property (
    $fell(alarm_o) && !$past(rst) |-> $past(cycle_tick) && evt_time == $past(time_stamp))
    else $error("alarm dropped off tick or unstamped");
  AST_START_DROP: assert property ($fell(start_o) && !$past(rst) |-> $past(cycle_tick))
    else $error("start dropped off tick");
  AST_DELAY_MIN: assert property ($rose(alarm_o) |-> start_cnt >= STEP_CYCLES)
    else $error("alarm before one delay step");
endmodule // ctsb_top_chk
bind ctsb_top ctsb_top_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .cycle_tick(cycle_tick), .block_in(block_in),
  .time_stamp(time_stamp), .start_o(start_o), .blocked_o(blocked_o), .alarm_o(alarm_o),
  .evt_valid(evt_valid), .evt_flags(evt_flags), .evt_time(evt_time)
);

/* File: testbench/ctsb_meas_model.sv */
// measurement path and blocking matrix model: cycle strobe, time base, blocking level
`timescale 1ns/1ps
module ctsb_meas_model #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic blk_req,
  output logic cycle_tick,
  output logic block_in,
  output logic [31:0] time_stamp
);
  logic [7:0] tick_cnt_reg;
  // free-running strobe, phase unrelated to any request
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 8'h00;
      cycle_tick <= 1'b0;
    end else begin
      tick_cnt_reg <= (tick_cnt_reg == 8'(TICK_CYCLES - 1)) ? 8'h00 : tick_cnt_reg + 8'h01;
      cycle_tick <= (tick_cnt_reg == 8'(TICK_CYCLES - 1));
    end
  end
  // one cycle of latency, far inside any delay step
  always_ff @(posedge clk) begin
    block_in <= blk_req;
    time_stamp <= rst ? 32'h0 : time_stamp + 32'h1;
  end
endmodule // ctsb_meas_model

/* File: testbench/test_ct_supervision_block.sv */
// self-checking bench for the supervision block
`timescale 1ns/1ps
module test_ct_supervision_block import ctsb_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, blk_req = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [15:0] phase_a = 16'h0, phase_b = 16'h0, phase_c = 16'h0, pos_seq = 16'h0;
  logic [15:0] neg_seq = 16'h0, phase_sum = 16'h0, residual_current = 16'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cycle_tick, block_in, start_o, blocked_o, alarm_o, evt_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, time_stamp, evt_time;
  logic [3:0] evt_flags;
  logic [4:0] evt_fault;
  logic [15:0] evt_remain;
  int error_cnt = 0;
  int n_compared = 0;
  int off_cnt = 0;
  always #5 clk = ~clk;
  ctsb_top #(.STEP_CYCLES(4)) uut (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cycle_tick(cycle_tick), .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
    .residual_current(residual_current), .phase_sum(phase_sum), .pos_seq(pos_seq),
    .neg_seq(neg_seq), .block_in(block_in), .time_stamp(time_stamp), .setting_group(3'h5),
    .start_o(start_o), .blocked_o(blocked_o), .alarm_o(alarm_o), .evt_valid(evt_valid),
    .evt_flags(evt_flags), .evt_time(evt_time), .evt_fault(evt_fault), .evt_remain(evt_remain)
  );
  ctsb_meas_model #(.TICK_CYCLES(8)) u_meas (
    .clk(clk), .rst(rst), .blk_req(blk_req), .cycle_tick(cycle_tick), .block_in(block_in),
    .time_stamp(time_stamp)
  );
  always @(posedge clk) if (evt_valid && evt_flags[1]) off_cnt++;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
  endtask
  task automatic meas(input logic [15:0] a, b, c, p, n);
    phase_a <= a;
    phase_b <= b;
    phase_c <= c;
    pos_seq <= p;
    neg_seq <= n;
  endtask
  // one phase lost: min/max 0, neg/pos about 50 percent
  task automatic fault();
    meas(16'h0000, 16'h0064, 16'h0064, 16'h0043, 16'h0021);
  endtask
  task automatic heal();
    meas(16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0000);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(A_CTRL, d, r);
    chk("ctrl reset", 32'(CTRL_RST), d);
    axi_rd(A_NPRATIO, d, r);
    chk("npratio reset", 32'(NPRATIO_RST), d);
    axi_rd(8'hfc, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(A_STATUS, 32'h0000_ffff, r);
    chk("status bresp", 32'(RESP_SLVERR), 32'(r));
    wr(A_DELAY, 32'h0000_0004);
  endtask
  task automatic t_alarm();
    logic [31:0] d;
    logic [1:0] r;
    fault();
    wt(9);
    chk("start", 32'h1, 32'(start_o));
    heal();
    wt(32);
    chk("alarm short fault", 32'h0, 32'(alarm_o));
    fault();
    wt(20);
    chk("alarm early", 32'h0, 32'(alarm_o));
    wt(21);
    chk("alarm", 32'h1, 32'(alarm_o));
    chk("evt fault", 32'h1c, 32'(evt_fault));
    chk("evt remain", 32'h0, 32'(evt_remain));
    heal();
    wt(9);
    chk("alarm cleared", 32'h0, 32'(alarm_o));
    wr(A_HSEL, 32'h0);
    axi_rd(A_HINFO, d, r);
    chk("hist group", 32'h5, 32'(d[10:8]));
    chk("hist code", 32'h0, 32'(d[0]));
    chk("hist fault", 32'h1c, 32'(d[7:3]));
    chk("hist remain", 32'h0, 32'(d[31:16]));
    axi_rd(A_HPH01, d, r);
    chk("hist phases", 32'h0064_0000, d);
    axi_rd(A_STATUS, d, r);
    chk("hist pointer", 32'h1, 32'(d[15:12]));
  endtask
  task automatic t_limits();
    meas(16'h0000, 16'h0082, 16'h0082, 16'h0057, 16'h002c);
    wt(17);
    chk("start over high", 32'h0, 32'(start_o));
    meas(16'h0000, 16'h0008, 16'h0008, 16'h0005, 16'h0003);
    wt(17);
    chk("start under low", 32'h0, 32'(start_o));
    // exactly 49 percent is not above the ratio setting
    meas(16'h0000, 16'h0064, 16'h0064, 16'h0064, 16'h0031);
    wt(17);
    chk("start ratio edge", 32'h0, 32'(start_o));
  endtask
  task automatic t_block();
    blk_req <= 1'b1;
    wt(1);
    fault();
    wt(10);
    chk("blocked", 32'h1, 32'(blocked_o));
    blk_req <= 1'b0;
    wt(10);
    chk("start after release", 32'h1, 32'(start_o));
    blk_req <= 1'b1;
    wt(10);
    chk("start cleared", 32'h0, 32'(start_o));
    wt(40);
    chk("no alarm blocked", 32'h0, 32'(alarm_o));
    blk_req <= 1'b0;
    heal();
    wt(10);
    chk("block released", 32'h0, 32'(blocked_o));
  endtask
  task automatic t_force();
    wr(A_CTRL, 32'h0000_001e);
    fault();
    wt(10);
    chk("forced block", 32'h1, 32'(blocked_o));
    wr(A_CTRL, 32'h0000_0018);
    wt(10);
    chk("force off start", 32'h1, 32'(start_o));
    heal();
    wt(10);
  endtask
  task automatic t_resid();
    int k;
    wr(A_CTRL, 32'h0000_0019);
    phase_sum <= 16'h0064;
    residual_current <= 16'h0064;
    fault();
    wt(17);
    chk("residual equal", 32'h0, 32'(start_o));
    residual_current <= 16'h0000;
    wt(50);
    chk("residual differs", 32'h1, 32'(alarm_o));
    k = off_cnt;
    // on-only selection plus compensation in one write
    wr(A_CTRL, 32'h0000_0029);
    wt(10);
    chk("compensated", 32'h0, 32'(alarm_o));
    chk("off filtered", 32'(k), 32'(off_cnt));
    wr(A_CTRL, 32'h0000_0018);
    heal();
    wt(10);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_alarm();
    t_limits();
    t_block();
    t_force();
    t_resid();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule // test_ct_supervision_block
